// ### bench/fxr_far_tx.sv
/*
 * Far-end transmitter model: scrambles, serialises and NRZI-codes 5B
 * code groups onto the receive line, sending idle whenever it has nothing.
 * Assumes a free-running recovered clock; bits launch 1 ns after its edge.
 */
module fxr_far_tx (
    input  wire logic link_clk,
    output logic      rx_nrzi
);
    timeunit 1ns;
    timeprecision 100ps;
    import fxr_pkg::*;

    // Key history, newest key in bit 0; seed is arbitrary but nonzero
    logic [10:0] key_hist = 11'h5A3;
    logic        key;
    logic        b;
    logic        bit_q[$];

    initial rx_nrzi = 1'b0;

    // One bit per cycle; ones fill gaps so the line always carries idle
    always @(posedge link_clk) begin
        #1;
        b        = (bit_q.size() > 0) ? bit_q.pop_front() : 1'b1;
        key      = key_hist[10] ^ key_hist[8];
        key_hist = {key_hist[9:0], key};
        rx_nrzi  = rx_nrzi ^ b ^ key;
    end

    // Single line bit, used to slip the group boundary
    task automatic put_bit(input logic v);
        bit_q.push_back(v);
    endtask

    // Whole code group, first bit from bit 4
    task automatic put_cg(input logic [4:0] g);
        for (int i = 4; i >= 0; i--) begin
            bit_q.push_back(g[i]);
        end
    endtask

    // Returns once every queued bit is on the line
    task automatic wait_empty();
        while (bit_q.size() != 0) begin
            @(posedge link_clk);
        end
    endtask
endmodule

// ### bench/fxr_rx_pcs_tb.sv
/*
 * Self-checking bench for the receive coding path: frames, error groups,
 * realignment, carrier sense and collision.
 * Assumes the far-end model fxr_far_tx and the shared package.
 */
module fxr_rx_pcs_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import fxr_pkg::*;

    localparam int         LIMIT   = 4000;
    localparam logic [4:0] ERR_NIB = 5'h10;
    localparam logic [4:0] DATA_CG [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B,
        5'h0E, 5'h0F, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
    localparam logic [4:0] BAD_CG [10] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h05,
        5'h06, 5'h08, 5'h0C, 5'h10, 5'h19};

    logic       sys_clk     = 1'b0;
    logic       sys_rst     = 1'b1;
    logic       link_clk    = 1'b0;
    logic       tx_active   = 1'b0;
    logic       full_duplex = 1'b0;
    logic       rx_nrzi;
    logic [3:0] rx_nib;
    logic       rx_nib_valid;
    logic       rx_dv;
    logic       rx_er;
    logic       crs;
    logic       col;
    logic [4:0] exp_q[$];
    logic [4:0] mon_q[$];
    int         bad_count = 0;
    int         n_checks  = 0;
    int         cycles    = 0;

    // Clocks: link period 6 ns with an odd offset, unrelated in phase
    initial begin
        forever #25 sys_clk = ~sys_clk;
    end
    initial begin
        #1.7;
        forever #3 link_clk = ~link_clk;
    end

    fxr_rx_pcs DUT (
        .sys_clk      (sys_clk),
        .sys_rst      (sys_rst),
        .link_clk     (link_clk),
        .rx_nrzi      (rx_nrzi),
        .tx_active    (tx_active),
        .full_duplex  (full_duplex),
        .rx_nib       (rx_nib),
        .rx_nib_valid (rx_nib_valid),
        .rx_dv        (rx_dv),
        .rx_er        (rx_er),
        .crs          (crs),
        .col          (col)
    );

    fxr_far_tx far (
        .link_clk (link_clk),
        .rx_nrzi  (rx_nrzi)
    );

    // Collect every nibble with its error flag; valid is a one-cycle pulse
    always @(posedge link_clk) begin
        if (rx_nib_valid === 1'b1) begin
            mon_q.push_back({rx_er, rx_nib});
        end
    end

    // Hang guard; the whole run needs about 130 sys_clk cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            bad_count++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [4:0] got, input logic [4:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Drain the line, then compare every nibble the MAC saw
    task automatic settle(input string name);
        far.wait_empty();
        repeat (40) @(posedge link_clk);
        chk({4'h0, rx_dv}, 5'h00);
        chk(5'(mon_q.size()), 5'(exp_q.size()));
        while (exp_q.size() > 0 && mon_q.size() > 0) begin
            chk(mon_q.pop_front(), exp_q.pop_front());
        end
        exp_q.delete();
        mon_q.delete();
        $display("test %s done", name);
    endtask

    // Start delimiter on the line, two preamble nibbles expected
    task automatic open_frame();
        far.put_cg(CG_J);
        far.put_cg(CG_K);
        exp_q.push_back({1'b0, NIB_PRE});
        exp_q.push_back({1'b0, NIB_PRE});
    endtask

    task automatic close_frame();
        far.put_cg(CG_T);
        far.put_cg(CG_R);
    endtask

    task automatic data(input int n);
        far.put_cg(DATA_CG[n]);
        exp_q.push_back({1'b0, 4'(n)});
    endtask

    // Every mode combination; crs and col follow one cycle after a change
    task automatic cc_table(input logic rx);
        logic [4:0] want;
        for (int m = 0; m < 4; m++) begin
            @(posedge sys_clk);
            #1;
            full_duplex = m[1];
            tx_active   = m[0];
            repeat (2) @(posedge sys_clk);
            // Look after the edge so the registered outputs have settled
            #1;
            want = {3'h0, rx | (!m[1] & m[0]), !m[1] & rx & m[0]};
            chk({3'h0, crs, col}, want);
        end
        #1;
        full_duplex = 1'b0;
        tx_active   = 1'b0;
    endtask

    // Idle only: descrambler locks, nothing reaches the MAC
    task automatic t_idle_lock();
        repeat (30) far.put_cg(CG_IDLE);
        settle("idle_lock");
    endtask

    // All sixteen data groups between delimiters
    task automatic t_data_table();
        open_frame();
        for (int i = 0; i < 16; i++) begin
            data(i);
        end
        close_frame();
        settle("data_table");
    endtask

    // Error symbol, every invalid group and a stray J inside a frame,
    // then a T followed by a data group, which must end the stream
    task automatic t_bad_groups();
        open_frame();
        data(9);
        far.put_cg(CG_H);
        exp_q.push_back(ERR_NIB);
        for (int i = 0; i < 10; i++) begin
            far.put_cg(BAD_CG[i]);
            exp_q.push_back(ERR_NIB);
        end
        far.put_cg(CG_J);
        exp_q.push_back(ERR_NIB);
        data(12);
        close_frame();
        open_frame();
        data(5);
        far.put_cg(CG_T);
        far.put_cg(DATA_CG[2]);
        exp_q.push_back(ERR_NIB);
        settle("bad_groups");
    endtask

    // Idle ends a stream; next frame starts three bits off the old boundary
    task automatic t_realign();
        open_frame();
        data(3);
        far.put_cg(CG_IDLE);
        repeat (3) far.put_bit(1'b1);
        open_frame();
        data(7);
        data(14);
        close_frame();
        settle("realign");
    endtask

    // Carrier and collision with and without receive activity
    task automatic t_carrier();
        cc_table(1'b0);
        open_frame();
        for (int i = 0; i < 50; i++) begin
            data(15);
        end
        close_frame();
        repeat (10) @(posedge sys_clk);
        chk({4'h0, rx_dv}, 5'h01);
        cc_table(1'b1);
        settle("carrier");
    endtask

    initial begin
        repeat (11) @(posedge sys_clk);
        chk({3'h0, crs, col}, 5'h00);
        @(posedge sys_clk);
        #1;
        sys_rst = 1'b0;
        t_idle_lock();
        t_data_table();
        t_bad_groups();
        t_realign();
        t_carrier();
        tally_and_finish();
    end
endmodule

// ### inc/fxr_pkg.sv
/*
 * Shared constants, types and code-group lookups for the 100 Mb/s
 * receive coding path. Assumes 5-bit code groups held with the first
 * received bit in bit 4.
 */
package fxr_pkg;

    localparam int SYM_W  = 5;
    localparam int NIB_W  = 4;
    localparam int LFSR_W = 11;
    localparam int HIST_W = 14;

    // Special code groups
    localparam logic [4:0] CG_IDLE = 5'h1F;
    localparam logic [4:0] CG_J    = 5'h18;
    localparam logic [4:0] CG_K    = 5'h11;
    localparam logic [4:0] CG_T    = 5'h0D;
    localparam logic [4:0] CG_R    = 5'h07;
    localparam logic [4:0] CG_H    = 5'h04;

    // Nibble put in place of each start delimiter symbol
    localparam logic [3:0] NIB_PRE = 4'h5;

    // Reset values and counts
    localparam logic [2:0]  DESER_LAST = 3'h4;
    localparam logic [3:0]  LOCK_WORDS = 4'hC;
    localparam logic [10:0] LFSR_RST   = 11'h000;
    localparam logic [13:0] HIST_RST   = 14'h3FFF;

    typedef enum logic [2:0] {
        CL_DATA, CL_IDLE, CL_J, CL_K, CL_T, CL_R, CL_ERR, CL_INV
    } fxr_cls_t;

    typedef enum logic [1:0] {
        ST_HUNT  = 2'b01,
        ST_FRAME = 2'b10
    } fxr_state_t;

    // Class of a code group
    function automatic fxr_cls_t fxr_cls(input logic [4:0] g);
        fxr_cls_t c;
        c = CL_DATA;
        case (g)
            CG_IDLE: c = CL_IDLE;
            CG_J:    c = CL_J;
            CG_K:    c = CL_K;
            CG_T:    c = CL_T;
            CG_R:    c = CL_R;
            CG_H:    c = CL_ERR;
            5'h00, 5'h01, 5'h02, 5'h03, 5'h05,
            5'h06, 5'h08, 5'h0C, 5'h10, 5'h19: c = CL_INV;
            default: c = CL_DATA;
        endcase
        return c;
    endfunction

    // Nibble of a code group; zero where none is defined
    function automatic logic [3:0] fxr_nib(input logic [4:0] g);
        logic [3:0] n;
        n = 4'h0;
        case (g)
            5'h1E: n = 4'h0;
            5'h09: n = 4'h1;
            5'h14: n = 4'h2;
            5'h15: n = 4'h3;
            5'h0A: n = 4'h4;
            5'h0B: n = 4'h5;
            5'h0E: n = 4'h6;
            5'h0F: n = 4'h7;
            5'h12: n = 4'h8;
            5'h13: n = 4'h9;
            5'h16: n = 4'hA;
            5'h17: n = 4'hB;
            5'h1A: n = 4'hC;
            5'h1B: n = 4'hD;
            5'h1C: n = 4'hE;
            5'h1D: n = 4'hF;
            CG_J, CG_K: n = NIB_PRE;
            default: n = 4'h0;
        endcase
        return n;
    endfunction

endpackage

// ### rtl/fxr_descram.sv
/*
 * Word-parallel descrambler for 5-bit words, polynomial x^11 + x^9 + 1.
 * Assumes the line carries idle while unlocked; the key is learnt
 * from idle and lock is kept once gained.
 */
module fxr_descram (
    input  wire logic                     link_clk,
    input  wire logic                     link_rst,
    input  wire logic                     in_valid,
    input  wire logic [fxr_pkg::SYM_W-1:0] in_word,
    output logic                          out_valid,
    output logic [fxr_pkg::SYM_W-1:0]     out_word,
    output logic                          locked
);
    import fxr_pkg::*;

    logic [LFSR_W-1:0] lfsr_reg;
    logic [3:0]        match_cnt_reg;
    logic [16:0]       step_run;
    logic [16:0]       step_load;

    // Five key bits per word; load mode assumes plain idle ones
    function automatic logic [16:0] fxr_step(input logic [10:0] st,
                                             input logic [4:0]  scr,
                                             input logic        load);
        logic [10:0] s;
        logic [4:0]  p;
        logic        m;
        logic        k;
        s = st;
        p = 5'h00;
        m = 1'b1;
        k = 1'b0;
        for (int i = 4; i >= 0; i--) begin
            k    = s[10] ^ s[8];
            p[i] = scr[i] ^ k;
            if (k != ~scr[i]) begin
                m = 1'b0;
            end
            s = {s[9:0], load ? ~scr[i] : k};
        end
        return {s, p, m};
    endfunction

    assign step_run  = fxr_step(lfsr_reg, in_word, 1'b0);
    assign step_load = fxr_step(lfsr_reg, in_word, 1'b1);

    // Key tracking and lock
    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            lfsr_reg      <= LFSR_RST;
            match_cnt_reg <= 4'h0;
            locked        <= 1'b0;
            out_valid     <= 1'b0;
            out_word      <= 5'h00;
        end else begin
            out_valid <= in_valid;
            if (in_valid) begin
                out_word <= step_run[5:1];
                if (locked) begin
                    lfsr_reg <= step_run[16:6];
                end else begin
                    lfsr_reg <= step_load[16:6];
                    if (!step_run[0]) begin
                        match_cnt_reg <= 4'h0;
                    end else if (match_cnt_reg == LOCK_WORDS) begin
                        locked <= 1'b1;
                    end else begin
                        match_cnt_reg <= match_cnt_reg + 4'h1;
                    end
                end
            end
        end
    end

    a_lock_hold : assert property (@(posedge link_clk) disable iff (link_rst)
        locked |=> locked)
        else $error("descrambler lost lock");

endmodule

// ### rtl/fxr_rx_pcs.sv
/*
 * Receive coding path: NRZI pin to MAC nibbles, plus carrier sense and
 * collision. Assumes link_clk is the recovered 125 MHz bit clock with
 * rx_nrzi launched on it, and tx_active, full_duplex on sys_clk.
 */
module fxr_rx_pcs (
    input  wire logic                     sys_clk,
    input  wire logic                     sys_rst,
    input  wire logic                     link_clk,
    input  wire logic                     rx_nrzi,
    input  wire logic                     tx_active,
    input  wire logic                     full_duplex,
    output logic [fxr_pkg::NIB_W-1:0]     rx_nib,
    output logic                          rx_nib_valid,
    output logic                          rx_dv,
    output logic                          rx_er,
    output logic                          crs,
    output logic                          col
);
    import fxr_pkg::*;

    logic              link_rst;
    logic              nrzi_s1_reg;
    logic              nrzi_s2_reg;
    logic              nrzi_prev_reg;
    logic              nrz_bit;
    logic [SYM_W-1:0]  sh_reg;
    logic [2:0]        cnt_reg;
    logic              word_valid_reg;
    logic [SYM_W-1:0]  word_reg;
    logic              ds_valid;
    logic [SYM_W-1:0]  ds_word;
    logic              ds_locked;
    logic [HIST_W-1:0] hist_reg;
    logic [HIST_W-1:0] hist_new;
    logic              jk_hit;
    logic [2:0]        jk_off;
    logic [2:0]        off_reg;
    logic [SYM_W-1:0]  grp;
    logic              gv;
    fxr_cls_t          cls;
    logic [NIB_W-1:0]  nib;
    fxr_state_t        state_reg;
    logic              t_pend_reg;
    logic              pre_pend_reg;
    logic              rx_frame;
    logic              rx_act_s;

    // Reset carried into the link domain
    fxr_sync u_rst_sync (
        .clk (link_clk),
        .rst (1'b0),
        .d   (sys_rst),
        .q   (link_rst)
    );

    // Pin capture then NRZI undo; a transition means one
    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            nrzi_s1_reg   <= 1'b0;
            nrzi_s2_reg   <= 1'b0;
            nrzi_prev_reg <= 1'b0;
        end else begin
            nrzi_s1_reg   <= rx_nrzi;
            nrzi_s2_reg   <= nrzi_s1_reg;
            nrzi_prev_reg <= nrzi_s2_reg;
        end
    end

    assign nrz_bit = nrzi_s2_reg ^ nrzi_prev_reg;

    // Free-running 5-bit deserialiser, first bit lands in bit 4
    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            sh_reg         <= 5'h00;
            cnt_reg        <= 3'h0;
            word_valid_reg <= 1'b0;
            word_reg       <= 5'h00;
        end else begin
            sh_reg         <= {sh_reg[3:0], nrz_bit};
            word_valid_reg <= (cnt_reg == DESER_LAST);
            if (cnt_reg == DESER_LAST) begin
                cnt_reg  <= 3'h0;
                word_reg <= {sh_reg[3:0], nrz_bit};
            end else begin
                cnt_reg <= cnt_reg + 3'h1;
            end
        end
    end

    fxr_descram u_descram (
        .link_clk  (link_clk),
        .link_rst  (link_rst),
        .in_valid  (word_valid_reg),
        .in_word   (word_reg),
        .out_valid (ds_valid),
        .out_word  (ds_word),
        .locked    (ds_locked)
    );

    // Bit history; J/K may end at any of five places in the new word
    assign hist_new = {hist_reg[8:0], ds_word};
    assign gv       = ds_valid && ds_locked;

    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            hist_reg <= HIST_RST;
        end else if (ds_valid) begin
            hist_reg <= hist_new;
        end
    end

    // Start delimiter search; lowest offset wins on a tie
    always_comb begin
        jk_hit = 1'b0;
        jk_off = 3'h0;
        for (int e = 4; e >= 0; e--) begin
            if (hist_new[e +: 10] == {CG_J, CG_K}) begin
                jk_hit = 1'b1;
                jk_off = 3'(e);
            end
        end
    end

    assign grp = hist_new[off_reg +: SYM_W];
    assign cls = fxr_cls(grp);
    assign nib = fxr_nib(grp);

    // Frame state: hunting for J/K or inside a stream
    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            state_reg <= ST_HUNT;
        end else begin
            unique case (state_reg)
                ST_HUNT: begin
                    if (gv && jk_hit) begin
                        state_reg <= ST_FRAME;
                    end
                end
                ST_FRAME: begin
                    if (gv && (t_pend_reg || cls == CL_IDLE)) begin
                        state_reg <= ST_HUNT;
                    end
                end
            endcase
        end
    end

    // Boundary is taken once and held for the whole stream
    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            off_reg <= 3'h0;
        end else if (state_reg == ST_HUNT && gv && jk_hit) begin
            off_reg <= jk_off;
        end
    end

    // T is held back one group so a following R can drop both
    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            t_pend_reg <= 1'b0;
        end else if (state_reg != ST_FRAME) begin
            t_pend_reg <= 1'b0;
        end else if (gv) begin
            t_pend_reg <= (cls == CL_T) && !t_pend_reg;
        end
    end

    // Second preamble nibble goes out the cycle after the first
    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            pre_pend_reg <= 1'b0;
        end else begin
            pre_pend_reg <= (state_reg == ST_HUNT) && gv && jk_hit;
        end
    end

    // MAC side nibbles; groups come only every fifth cycle, so the
    // extra preamble nibble never collides with a data group
    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            rx_nib       <= 4'h0;
            rx_nib_valid <= 1'b0;
            rx_dv        <= 1'b0;
            rx_er        <= 1'b0;
        end else begin
            rx_nib_valid <= 1'b0;
            rx_er        <= 1'b0;
            if (state_reg == ST_HUNT && gv && jk_hit) begin
                rx_nib       <= NIB_PRE;
                rx_nib_valid <= 1'b1;
                rx_dv        <= 1'b1;
            end else if (pre_pend_reg) begin
                rx_nib       <= NIB_PRE;
                rx_nib_valid <= 1'b1;
            end else if (state_reg == ST_FRAME && gv) begin
                if (t_pend_reg) begin
                    if (cls == CL_R) begin
                        rx_dv <= 1'b0;
                    end else begin
                        rx_nib       <= 4'h0;
                        rx_nib_valid <= 1'b1;
                        rx_er        <= 1'b1;
                    end
                end else if (cls == CL_IDLE) begin
                    rx_dv <= 1'b0;
                end else if (cls == CL_DATA) begin
                    rx_nib       <= nib;
                    rx_nib_valid <= 1'b1;
                end else if (cls != CL_T) begin
                    rx_nib       <= 4'h0;
                    rx_nib_valid <= 1'b1;
                    rx_er        <= 1'b1;
                end
            end else if (state_reg == ST_HUNT) begin
                rx_dv <= 1'b0;
            end
        end
    end

    assign rx_frame = (state_reg == ST_FRAME);

    // Receive activity crosses into the system domain as a level
    fxr_sync u_act_sync (
        .clk (sys_clk),
        .rst (sys_rst),
        .d   (rx_frame),
        .q   (rx_act_s)
    );

    // Carrier sense and collision by duplex mode
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            crs <= 1'b0;
            col <= 1'b0;
        end else begin
            crs <= full_duplex ? rx_act_s : (rx_act_s || tx_active);
            col <= !full_duplex && rx_act_s && tx_active;
        end
    end

    sequence s_jk_seen;
        state_reg == ST_HUNT && gv && jk_hit;
    endsequence

    sequence s_two_pre;
        rx_nib_valid && rx_nib == NIB_PRE && rx_dv ##1
        rx_nib_valid && rx_nib == NIB_PRE;
    endsequence

    a_jk_preamble : assert property (@(posedge link_clk) disable iff (link_rst)
        s_jk_seen |=> s_two_pre)
        else $error("start delimiter not replaced by two preamble nibbles");

    a_data_map : assert property (@(posedge link_clk) disable iff (link_rst)
        (rx_frame && gv && !t_pend_reg && cls == CL_DATA)
        |=> (rx_nib_valid && !rx_er && rx_nib == $past(nib)))
        else $error("data group not decoded to its nibble");

    // A J/K hit in hunt or a held T owns the next nibble, not the idle
    a_idle_no_nib : assert property (@(posedge link_clk) disable iff (link_rst)
        (gv && cls == CL_IDLE && !pre_pend_reg && !t_pend_reg
         && !(state_reg == ST_HUNT && jk_hit)) |=> !rx_nib_valid)
        else $error("idle produced a nibble");

    a_t_stripped : assert property (@(posedge link_clk) disable iff (link_rst)
        (rx_frame && gv && cls == CL_T && !t_pend_reg) |=> !rx_nib_valid)
        else $error("end delimiter reached the MAC");

    a_err_flag : assert property (@(posedge link_clk) disable iff (link_rst)
        (rx_frame && gv && !t_pend_reg && (cls == CL_ERR || cls == CL_INV))
        |=> (rx_nib_valid && rx_er && rx_dv))
        else $error("bad group in frame without receive error");

    a_end_release : assert property (@(posedge link_clk) disable iff (link_rst)
        (rx_frame && gv && t_pend_reg && cls == CL_R)
        |=> (state_reg == ST_HUNT && !rx_dv && !rx_nib_valid))
        else $error("end delimiter did not close the stream");

    a_bound_hold : assert property (@(posedge link_clk) disable iff (link_rst)
        (rx_frame && $past(rx_frame)) |-> off_reg == $past(off_reg))
        else $error("group boundary moved inside a stream");

    a_deser_period : assert property (@(posedge link_clk) disable iff (link_rst)
        word_valid_reg |=> (!word_valid_reg) [*4] ##1 word_valid_reg)
        else $error("deserialiser word spacing not five bits");

    a_col_half : assert property (@(posedge sys_clk) disable iff (sys_rst)
        (!full_duplex && rx_act_s && tx_active) |=> col)
        else $error("collision missed in half duplex");

    a_col_full : assert property (@(posedge sys_clk) disable iff (sys_rst)
        full_duplex |=> !col)
        else $error("collision reported in full duplex");

    a_crs_half : assert property (@(posedge sys_clk) disable iff (sys_rst)
        (!full_duplex && (rx_act_s || tx_active)) |=> crs)
        else $error("carrier sense missing in half duplex");

    a_crs_full : assert property (@(posedge sys_clk) disable iff (sys_rst)
        (full_duplex && tx_active && !rx_act_s) |=> !crs)
        else $error("carrier sense on own transmit in full duplex");

endmodule

// ### rtl/fxr_sync.sv
/*
 * Two-flop level synchroniser.
 * Assumes d is a level that holds for at least two clk periods.
 */
module fxr_sync (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic d,
    output logic      q
);
    logic meta_reg;

    // First stage feeds only the second
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_reg <= 1'b0;
            q        <= 1'b0;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule
